// ### ebt_timer.sv
`timescale 1ns/1ps
`include "ebt_defines.svh"
module ebt_timer #(
    parameter int PHASES = `EBT_PHASES
) (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_reset,
    // Configuration bits
    input  wire logic               i_clock_source_select,
    input  wire logic               i_source_edge_select,
    input  wire logic               i_prescaler_assignment,
    input  wire ebt_pkg::ebt_ratio_t i_prescale_select,
    input  wire logic               i_overflow_irq_enable,
    input  wire logic               i_sleep,
    // External count pin
    input  wire logic               i_external_count_input,
    // Count register access
    input  wire logic               i_count_write,
    input  wire ebt_pkg::ebt_count_t i_count_wdata,
    input  wire logic               i_flag_clear,
    // Watchdog prescaler share
    input  wire logic               i_watchdog_tick,
    output logic                    o_watchdog_tick,
    // Status
    output ebt_pkg::ebt_count_t     o_count_register,
    output logic                    o_overflow_flag,
    output logic                    o_overflow_irq
);
    import ebt_pkg::*;

    //--------------------------------------------------
    // State
    //--------------------------------------------------
    typedef struct packed {
        ebt_phase_e phase;
        logic [7:0] count;
        logic       flag;
        logic [1:0] hold;
        logic       pin_d;
        logic       smp;
        logic       rise_pend;
        logic       sync_d;
        logic       wd_d;
        logic       wd_tick;
    } ebt_state_s;
    ebt_state_s state;
    ebt_state_s next_state;

    logic pre_div;
    logic pre_src_tick;
    logic pin_edge;
    logic sync_src;
    logic inc_en;
    logic inc;
    logic wrap;
    logic instr_tick;
    logic src_rise;

    //--------------------------------------------------
    // Shared prescaler
    //--------------------------------------------------
    // Edge on chosen polarity
    assign pin_edge = i_source_edge_select
                    ? (state.pin_d & ~i_external_count_input)
                    : (~state.pin_d & i_external_count_input);
    // Phase four ends a cycle; none in sleep, so hold cannot run down
    assign instr_tick = (state.phase == EBT_PH4) & ~i_sleep;
    // Prescaler input: watchdog or count source
    assign pre_src_tick = i_prescaler_assignment ? i_watchdog_tick
                        : (i_clock_source_select ? pin_edge : instr_tick);

    ebt_prescaler u_pre (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_tick  (pre_src_tick & ~i_sleep),
        .i_ratio (i_prescale_select),
        .o_div   (pre_div)
    );

    // Pin direct when prescaler given away
    assign sync_src = i_prescaler_assignment
                    ? (i_external_count_input ^ i_source_edge_select) : pre_div;

    //--------------------------------------------------
    // Synchroniser
    //--------------------------------------------------
    // Rise between two samples; two-clock levels cannot slip
    assign src_rise = sync_src & ~state.smp;

    //--------------------------------------------------
    // Increment decision
    //--------------------------------------------------
    // A write wins over an increment in the same cycle
    assign inc_en = ~i_sleep & (state.hold == 2'h0) & ~i_count_write;
    // At most one step per instruction cycle in every mode
    always_comb begin
        if (i_clock_source_select) begin
            inc = instr_tick & state.rise_pend;
        end else if (i_prescaler_assignment) begin
            inc = instr_tick;
        end else begin
            inc = instr_tick & pre_div & ~state.sync_d;
        end
    end
    assign wrap = inc_en & inc & (state.count == `EBT_COUNT_MAX);

    //--------------------------------------------------
    // Next state
    //--------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.phase = state.phase;
        if (!i_sleep) begin
            case (state.phase)
                EBT_PH1: next_state.phase = EBT_PH2;
                EBT_PH2: next_state.phase = EBT_PH3;
                EBT_PH3: next_state.phase = EBT_PH4;
                default: next_state.phase = EBT_PH1;
            endcase
        end
        next_state.pin_d = i_external_count_input;
        // Sample source on phases two and four
        if (!i_sleep && state.phase == EBT_PH2) begin
            next_state.smp       = sync_src;
            next_state.rise_pend = state.rise_pend | src_rise;
        end
        // Phase four hands the captured rise to the counter
        if (instr_tick) begin
            next_state.smp       = sync_src;
            next_state.rise_pend = src_rise;
        end
        if (!i_clock_source_select && !i_prescaler_assignment && instr_tick) begin
            next_state.sync_d = pre_div;
        end
        // Write inhibit for two instruction cycles
        // A second write restarts a running hold
        if (i_count_write) begin
            next_state.count = i_count_wdata;
            next_state.hold = `EBT_WRITE_HOLD;
        end else begin
            if (instr_tick && state.hold != 2'h0) begin
                next_state.hold = state.hold - 2'h1;
            end
            if (inc_en && inc) begin
                next_state.count = state.count + 8'h01;
            end
        end
        // Set beats clear; only software clears
        if (wrap) begin
            next_state.flag = 1'b1;
        end else if (i_flag_clear) begin
            next_state.flag = 1'b0;
        end
        // Watchdog strobe on each rise of the divided level while the prescaler is assigned
        next_state.wd_d = pre_div;
        next_state.wd_tick = i_prescaler_assignment & pre_div & ~state.wd_d;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    //--------------------------------------------------
    // Outputs
    //--------------------------------------------------
    assign o_count_register = state.count;
    assign o_overflow_flag  = state.flag;
    assign o_overflow_irq   = state.flag & i_overflow_irq_enable;
    assign o_watchdog_tick  = state.wd_tick;

    //--------------------------------------------------
    // Assertions
    //--------------------------------------------------
    property p_wrap_sets;
        @(posedge i_clk) disable iff (i_reset)
        wrap |=> o_overflow_flag && o_count_register == 8'h00;
    endproperty
    a_wrap_sets: assert property (p_wrap_sets) else $error("flag not set");

    property p_flag_sticky;
        @(posedge i_clk) disable iff (i_reset)
        o_overflow_flag && !i_flag_clear |=> o_overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_irq_mask;
        @(posedge i_clk) disable iff (i_reset)
        o_overflow_irq == (o_overflow_flag && i_overflow_irq_enable);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq gate wrong");

    property p_write_hold;
        @(posedge i_clk) disable iff (i_reset)
        i_count_write ##1 (!i_count_write)[*4] |-> $stable(o_count_register);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write hold");

    property p_sleep_stop;
        @(posedge i_clk) disable iff (i_reset)
        i_sleep && !i_count_write |=> $stable(o_count_register);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("count in sleep");

    property p_timer_rate;
        @(posedge i_clk) disable iff (i_reset)
        !i_clock_source_select && i_prescaler_assignment && !i_sleep
        && !i_count_write && state.hold == 2'h0 && instr_tick
        |=> o_count_register == $past(o_count_register) + 8'h01;
    endproperty
    a_timer_rate: assert property (p_timer_rate) else $error("timer rate");

    property p_only_step;
        @(posedge i_clk) disable iff (i_reset)
        !i_count_write |=> o_count_register == $past(o_count_register)
        || o_count_register == $past(o_count_register) + 8'h01;
    endproperty
    a_only_step: assert property (p_only_step) else $error("bad step");

    property p_ext_sync;
        @(posedge i_clk) disable iff (i_reset)
        $past(i_clock_source_select) && !$past(i_count_write)
        && o_count_register != $past(o_count_register) |-> $past(state.rise_pend);
    endproperty
    a_ext_sync: assert property (p_ext_sync) else $error("unsynced");

    // Count register, write hold and sleep checks
    property p_write_load;
        @(posedge i_clk) disable iff (i_reset)
        i_count_write |=> o_count_register == $past(i_count_wdata)
        && state.hold == `EBT_WRITE_HOLD;
    endproperty
    a_write_load: assert property (p_write_load) else $error("write not loaded");

    property p_hold_max;
        @(posedge i_clk) disable iff (i_reset)
        state.hold <= `EBT_WRITE_HOLD;
    endproperty
    a_hold_max: assert property (p_hold_max) else $error("hold overrun");

    property p_tick_only;
        @(posedge i_clk) disable iff (i_reset)
        !i_count_write && !instr_tick |=> $stable(o_count_register);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("count off tick");

    property p_pend_count;
        @(posedge i_clk) disable iff (i_reset)
        i_clock_source_select && inc_en && instr_tick && state.rise_pend
        |=> o_count_register == $past(o_count_register) + 8'h01;
    endproperty
    a_pend_count: assert property (p_pend_count) else $error("edge lost");

    property p_prescaled_step;
        @(posedge i_clk) disable iff (i_reset)
        !i_clock_source_select && !i_prescaler_assignment && inc_en && instr_tick
        && pre_div && !state.sync_d |=> o_count_register == $past(o_count_register) + 8'h01;
    endproperty
    a_prescaled_step: assert property (p_prescaled_step) else $error("ratio step");

    property p_sleep_phase;
        @(posedge i_clk) disable iff (i_reset)
        i_sleep |=> $stable(state.phase);
    endproperty
    a_sleep_phase: assert property (p_sleep_phase) else $error("phase in sleep");

    property p_sleep_flag;
        @(posedge i_clk) disable iff (i_reset)
        i_sleep && !i_flag_clear |=> $stable(o_overflow_flag);
    endproperty
    a_sleep_flag: assert property (p_sleep_flag) else $error("flag in sleep");

    // Flag and request checks
    property p_flag_rise;
        @(posedge i_clk) disable iff (i_reset)
        $rose(o_overflow_flag) |-> $past(wrap);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag without wrap");

    property p_flag_clear;
        @(posedge i_clk) disable iff (i_reset)
        i_flag_clear && !wrap |=> !o_overflow_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("clear ignored");

    property p_irq_off;
        @(posedge i_clk) disable iff (i_reset)
        !i_overflow_irq_enable |-> !o_overflow_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked request");

    // Prescaler and synchroniser checks
    property p_wd_gate;
        @(posedge i_clk) disable iff (i_reset)
        !i_prescaler_assignment |=> !o_watchdog_tick;
    endproperty
    a_wd_gate: assert property (p_wd_gate) else $error("watchdog strobe");

    property p_sample_phase;
        @(posedge i_clk) disable iff (i_reset)
        (i_sleep || state.phase != EBT_PH2) && !instr_tick |=> $stable(state.smp);
    endproperty
    a_sample_phase: assert property (p_sample_phase) else $error("sample off phase");
endmodule : ebt_timer

// ### ebt_defines.svh
// Summary of operation
// - Clear source select: count instruction cycles
// - Count write holds value two cycles
// - Set source select: count external edges
// - Edge select zero rising, one falling
// - Assignment bit routes prescaler counter or watchdog
// - Prescaler count hidden and not loadable
// - Ratios 1:2 up to 1:256
// - Rollover FFh to 00h sets overflow flag
// - Enable bit masks request, flag still sets
// - Flag stays until software clears it
// - Sleep stops counting entirely
// - Unassigned prescaler: pin feeds synchroniser directly
// - Sample prescaler output on phases two, four
// - Ripple divider symmetric; source period limit
// - Counter updates after synchroniser captures edge
`ifndef EBT_DEFINES_SVH
`define EBT_DEFINES_SVH
`define EBT_COUNT_RESET    8'h00
`define EBT_COUNT_MAX      8'hFF
`define EBT_PRESCALE_RESET 8'h00
`define EBT_PHASES         4
`define EBT_PHASE_SECOND   2'h1
`define EBT_PHASE_FOURTH   2'h2
`define EBT_WRITE_HOLD     2'h2
`endif

// ### ebt_pkg.sv
package ebt_pkg;
    typedef logic [7:0] ebt_count_t;
    typedef logic [2:0] ebt_ratio_t;
    typedef enum logic [1:0] {
        EBT_PH1 = 2'h0,
        EBT_PH2 = 2'h1,
        EBT_PH3 = 2'h3,
        EBT_PH4 = 2'h2
    } ebt_phase_e;
endpackage : ebt_pkg

// ### ebt_prescaler.sv
`timescale 1ns/1ps
`include "ebt_defines.svh"
module ebt_prescaler (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    // Count strobe and ratio
    input  wire logic              i_tick,
    input  wire ebt_pkg::ebt_ratio_t i_ratio,
    // Divided level
    output logic                   o_div
);
    import ebt_pkg::*;
    typedef struct packed {
        logic [7:0] cnt;
    } ebt_pre_s;
    ebt_pre_s state;
    ebt_pre_s next_state;

    // Hidden divide chain, no load path
    always_comb begin
        next_state = state;
        if (i_tick) begin
            next_state.cnt = state.cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state.cnt <= `EBT_PRESCALE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Bit n gives symmetric divide by 2^(n+1)
    assign o_div = state.cnt[i_ratio];

    // Divide chain moves only on a strobe, never by a load
    property p_pre_hold;
        @(posedge i_clk) disable iff (i_reset)
        !i_tick |=> $stable(state.cnt);
    endproperty
    a_pre_hold: assert property (p_pre_hold) else $error("prescaler moved");
endmodule : ebt_prescaler

// ### ebt_pin_source.sv
`timescale 1ns/1ps
module ebt_pin_source (
    // Clock
    input  wire logic i_clk,
    // Count pin level
    output logic      o_pin
);
    initial o_pin = 1'b0;
    // Set a level just after a falling edge
    task automatic drive(input logic v);
        @(negedge i_clk);
        o_pin = v;
    endtask : drive
    // Each level held half clocks, one clock when half is one
    task automatic pulses(input int n, input int half);
        repeat (n) begin
            drive(1'b1);
            repeat (half - 1) @(negedge i_clk);
            drive(1'b0);
            repeat (half - 1) @(negedge i_clk);
        end
    endtask : pulses
endmodule : ebt_pin_source

// ### tb_eight_bit_timer_counter_prescaled.sv
`timescale 1ns/1ps
module tb_eight_bit_timer_counter_prescaled;
    import ebt_pkg::*;
    logic       clk = 0, rst = 1, css = 0, ses = 0, asg = 1, ovie = 0;
    logic       slp = 0, cw = 0, fc = 0, wdi = 0, pin, wdo, ovf, irq;
    ebt_count_t wd = 8'h00, cnt, c0;
    ebt_ratio_t ps = 3'h0;
    int         errors = 0, n_compared = 0, cyc = 0, n = 0;
    // ----------------------------------------
    // Clock, design and pin source
    // ----------------------------------------
    always #2.5 clk = ~clk;
    ebt_timer u_dut (.i_clk(clk), .i_reset(rst), .i_clock_source_select(css),
        .i_source_edge_select(ses), .i_prescaler_assignment(asg),
        .i_prescale_select(ps), .i_overflow_irq_enable(ovie), .i_sleep(slp),
        .i_external_count_input(pin), .i_count_write(cw), .i_count_wdata(wd),
        .i_flag_clear(fc), .i_watchdog_tick(wdi), .o_watchdog_tick(wdo),
        .o_count_register(cnt), .o_overflow_flag(ovf), .o_overflow_irq(irq));
    ebt_pin_source u_src (.i_clk(clk), .o_pin(pin));
    // Watchdog pulses counted, hang cut short
    always @(posedge clk) begin
        cyc++;
        if (wdo === 1'b1) n++;
        if (cyc == 40000) begin
            errors++;
            test_done();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmp_count(input ebt_count_t got, input ebt_count_t exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_count
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic write_count(input ebt_count_t v);
        @(negedge clk);
        cw = 1'b1;
        wd = v;
        @(negedge clk);
        cw = 1'b0;
    endtask : write_count
    task automatic test_done();
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(12);
        rst = 0;
        write_count(8'h40);
        cmp_count(cnt, 8'h40);
        tick(8);
        cmp_count(cnt, 8'h40);
        tick(4);
        cmp_count(cnt, 8'h41);
        tick(40);
        cmp_count(cnt, 8'h4B);
        // Masked wrap, then unmask and clear
        write_count(8'hFF);
        tick(12);
        cmp_count(cnt, 8'h00);
        tick(1);
        cmp_bit(ovf, 1'b1);
        cmp_bit(irq, 1'b0);
        ovie = 1;
        tick(200);
        cmp_bit(irq, 1'b1);
        cmp_bit(ovf, 1'b1);
        fc = 1;
        tick(1);
        fc = 0;
        cmp_bit(ovf, 1'b0);
        cmp_bit(irq, 1'b0);
        // Sleep freezes the count
        slp = 1;
        tick(1);
        c0 = cnt;
        tick(100);
        cmp_count(cnt, c0);
        slp = 0;
        // Every ratio, four steps per window
        asg = 0;
        for (int s = 0; s < 8; s++) begin
            ps = 3'(s);
            tick(32 << s);
            c0 = cnt;
            tick(32 << s);
            cmp_bit(8'(cnt - c0) inside {[8'h03:8'h05]}, 1'b1);
        end
        // Pin edges, both polarities
        asg = 1;
        css = 1;
        for (int e = 0; e < 2; e++) begin
            ses = e[0];
            tick(16);
            c0 = cnt;
            u_src.drive(1'b1);
            tick(16);
            cmp_count(cnt, e == 0 ? c0 + 8'h01 : c0);
            u_src.drive(1'b0);
            tick(1);
            cmp_count(cnt, e == 0 ? c0 + 8'h01 : c0);
            tick(16);
            cmp_count(cnt, c0 + 8'h01);
        end
        c0 = cnt;
        u_src.pulses(5, 2);
        tick(16);
        cmp_count(cnt, c0 + 8'h05);
        asg = 0;
        ps = 3'h0;
        tick(16);
        c0 = cnt;
        u_src.pulses(8, 4);
        tick(16);
        cmp_bit(8'(cnt - c0) inside {[8'h03:8'h05]}, 1'b1);
        // Watchdog takes the prescaler
        asg = 1;
        ps = 3'h1;
        n = 0;
        repeat (32) begin
            wdi = 1;
            tick(1);
            wdi = 0;
            tick(3);
        end
        tick(8);
        cmp_bit(n inside {[7:9]}, 1'b1);
        test_done();
    end
endmodule : tb_eight_bit_timer_counter_prescaled
